// *** twis_pkg.sv ***
// Package: constants, states and helpers of the tooth wheel start-up switch
package twis_pkg;

   localparam int unsigned FIELD_W      = 12;
   localparam int unsigned CLK_MHZ      = 100;
   // Times in microseconds as given
   localparam int unsigned FAIL_HIZ_US  = 2600;
   localparam int unsigned TOTAL_RST_US = 1000;
   localparam int unsigned SEARCH_US    = 1200;
   // Least times round up, longest times round down
   localparam int unsigned FAIL_HIZ_CYC  = FAIL_HIZ_US * CLK_MHZ;
   localparam int unsigned TOTAL_RST_CYC = TOTAL_RST_US * CLK_MHZ - 1;
   localparam int unsigned SEARCH_CYC    = SEARCH_US * CLK_MHZ;
   localparam int unsigned CNT_W         = 20;

   localparam logic [FIELD_W-1:0] HYST_DEFAULT = 12'h0010;
   localparam logic [FIELD_W-1:0] THR_RESET    = 12'h0000;
   localparam logic [CNT_W-1:0]   CNT_RESET    = 20'h0_0000;

   // Register bank offsets (byte addresses)
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQST  = 4'h8;
   localparam logic [3:0] ADDR_IRQMSK = 4'hC;

   // Event bit positions
   localparam int unsigned EV_SWITCH = 0;
   localparam int unsigned EV_SEARCH = 1;
   localparam int unsigned EV_FAIL   = 2;
   localparam int unsigned EV_W      = 3;

   typedef enum logic [2:0] {
      TWIS_RESET   = 3'b000,
      TWIS_LOAD    = 3'b001,
      TWIS_SEARCH  = 3'b010,
      TWIS_INITIAL = 3'b011,
      TWIS_PRECAL  = 3'b100,
      TWIS_CAL     = 3'b101,
      TWIS_FAILHIZ = 3'b110,
      TWIS_FAILLOW = 3'b111
   } twis_phase_e;

   // Saturating add/sub for threshold band edges
   function automatic logic [FIELD_W-1:0] twis_sat_add(
      input logic [FIELD_W-1:0] a,
      input logic [FIELD_W-1:0] b);
      logic [FIELD_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      twis_sat_add = s[FIELD_W] ? {FIELD_W{1'b1}} : s[FIELD_W-1:0];
   endfunction : twis_sat_add

   function automatic logic [FIELD_W-1:0] twis_sat_sub(
      input logic [FIELD_W-1:0] a,
      input logic [FIELD_W-1:0] b);
      twis_sat_sub = (a > b) ? (a - b) : {FIELD_W{1'b0}};
   endfunction : twis_sat_sub

endpackage : twis_pkg

// *** twis_hyst_cmp.sv ***
// Hysteresis comparator of field against threshold
module twis_hyst_cmp
   import twis_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               clr,
   input  wire logic               sample_vld,
   input  wire logic [FIELD_W-1:0] field,
   input  wire logic [FIELD_W-1:0] threshold,
   input  wire logic [FIELD_W-1:0] hyst,
   output      logic               tooth
);
   logic tooth_reg;
   logic tooth_next;

   // Band symmetric about threshold; holds state inside the band
   always_comb begin
      tooth_next = tooth_reg;
      if (clr) begin
         tooth_next = 1'b0;
      end else if (sample_vld) begin
         if (field > twis_sat_add(threshold, hyst)) begin
            tooth_next = 1'b1;
         end else if (field < twis_sat_sub(threshold, hyst)) begin
            tooth_next = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tooth_reg <= 1'b0;
      end else begin
         tooth_reg <= tooth_next;
      end
   end

   assign tooth = tooth_reg;
endmodule : twis_hyst_cmp

// *** twis_field_search.sv ***
// Successive approximation search of a static field value
module twis_field_search
   import twis_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               start,
   input  wire logic               sample_vld,
   input  wire logic [FIELD_W-1:0] field,
   output      logic               busy,
   output      logic [FIELD_W-1:0] result
);
   logic [FIELD_W-1:0] trial_reg;
   logic [FIELD_W-1:0] trial_next;
   logic [FIELD_W-1:0] bit_reg;
   logic [FIELD_W-1:0] bit_next;
   logic               busy_reg;
   logic               busy_next;

   // One bit per sample; needs no target movement
   always_comb begin
      trial_next = trial_reg;
      bit_next   = bit_reg;
      busy_next  = busy_reg;
      if (start) begin
         trial_next = {1'b1, {(FIELD_W-1){1'b0}}};
         bit_next   = {1'b1, {(FIELD_W-1){1'b0}}};
         busy_next  = 1'b1;
      end else if (busy_reg && sample_vld) begin
         if (field < trial_reg) begin
            trial_next = trial_reg & ~bit_reg;
         end
         bit_next = bit_reg >> 1;
         if (bit_reg[0]) begin
            busy_next = 1'b0;
         end else begin
            trial_next = trial_next | (bit_reg >> 1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         trial_reg <= THR_RESET;
         bit_reg   <= THR_RESET;
         busy_reg  <= 1'b0;
      end else begin
         trial_reg <= trial_next;
         bit_reg   <= bit_next;
         busy_reg  <= busy_next;
      end
   end

   assign busy   = busy_reg;
   assign result = trial_reg;
endmodule : twis_field_search

// *** twis_top.sv ***
// Start-up switching logic of the tooth wheel sensor
// How it works
// - Default polarity: tooth drives output low
// - Default polarity: notch releases output high
// - Stored polarity bit inverts output sense
// - Phases: initial, pre-calibrated, calibrated
// - Initial phase compares samples with threshold
// - Comparison uses hysteresis against noise
// - Threshold may be reprogrammed any time; code takes a new value only when customer programmed
// - Supplier-only memory starts automatic search
// - Search result becomes initial threshold
// - Search works on static field
// - Customer programmed: compare stored threshold
// - Memory failure: float 2.6ms, then low
// - Every power-up returns to initial phase
// - Total reset: output high, initial within 1ms
// - Unprogrammed: hold output 1200us during search
//
// Added by the designer: the register addresses and the Avalon-MM register port.
module twis_top
   import twis_pkg::*;
#(
   parameter int unsigned FAIL_HIZ_CYCLES  = FAIL_HIZ_CYC,
   parameter int unsigned TOTAL_RST_CYCLES = TOTAL_RST_CYC,
   parameter int unsigned SEARCH_CYCLES    = SEARCH_CYC
)
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               sample_vld,
   input  wire logic [FIELD_W-1:0] field,
   input  wire logic               nvm_customer_prog,
   input  wire logic               nvm_polarity,
   input  wire logic               nvm_fail,
   input  wire logic [FIELD_W-1:0] stored_start_threshold,
   input  wire logic               out_pin_in,
   output      logic               out_pin_o,
   output      logic               out_pin_oe,
   output      logic [2:0]         phase,
   input  wire logic               precal_done,
   input  wire logic               cal_done,
   input  wire logic [3:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   output      logic [31:0]        avs_readdata,
   output      logic               avs_waitrequest,
   output      logic               irq
);
   twis_phase_e        phase_reg;
   twis_phase_e        phase_next;
   logic [CNT_W-1:0]   cnt_reg;
   logic [CNT_W-1:0]   cnt_next;
   logic               cust_reg;
   logic               cust_next;
   logic               pol_reg;
   logic               pol_next;
   logic [FIELD_W-1:0] thr_reg;
   logic [FIELD_W-1:0] thr_next;
   logic               level_reg;
   logic               level_next;
   logic               oe_reg;
   logic               oe_next;
   logic [FIELD_W-1:0] hyst_reg;
   logic [FIELD_W-1:0] hyst_next;
   logic [EV_W-1:0]    irq_st_reg;
   logic [EV_W-1:0]    irq_st_next;
   logic [EV_W-1:0]    irq_msk_reg;
   logic [EV_W-1:0]    irq_msk_next;
   logic [31:0]        rdata_reg;
   logic [31:0]        rdata_next;
   logic               ack_reg;
   logic               ack_next;
   logic [2:0]         pin_sync_reg;
   logic               search_start;
   logic               search_busy;
   logic [FIELD_W-1:0] search_result;
   logic               tooth;
   logic               cmp_clr;
   logic               want_low;
   logic [EV_W-1:0]    ev;
   logic               wr_irq_st;

   // Comparator with symmetric hysteresis band
   twis_hyst_cmp u_cmp (
      .clk        (clk),
      .rst_n      (rst_n),
      .clr        (cmp_clr),
      .sample_vld (sample_vld),
      .field      (field),
      .threshold  (thr_reg),
      .hyst       (hyst_reg),
      .tooth      (tooth)
   );

   twis_field_search u_search (
      .clk        (clk),
      .rst_n      (rst_n),
      .start      (search_start),
      .sample_vld (sample_vld),
      .field      (field),
      .busy       (search_busy),
      .result     (search_result)
   );

   // Live memory value: cust_reg is only loaded at the end of this phase
   assign search_start = (phase_reg == TWIS_LOAD) && !nvm_customer_prog
                         && !nvm_fail;
   assign cmp_clr      = (phase_reg == TWIS_LOAD);
   // Tooth means low output unless polarity inverted
   assign want_low     = tooth ^ pol_reg;

   // Phase sequencing and output control
   always_comb begin
      phase_next = phase_reg;
      cnt_next   = cnt_reg;
      cust_next  = cust_reg;
      pol_next   = pol_reg;
      thr_next   = thr_reg;
      level_next = level_reg;
      oe_next    = oe_reg;
      case (phase_reg)
         TWIS_RESET: begin
            oe_next  = 1'b0;
            cnt_next = cnt_reg + 20'h0_0001;
            if (cnt_reg >= CNT_W'(TOTAL_RST_CYCLES)) begin
               phase_next = TWIS_LOAD;
               cnt_next   = CNT_RESET;
            end
         end
         TWIS_LOAD: begin
            cust_next = nvm_customer_prog;
            pol_next  = nvm_polarity;
            thr_next  = stored_start_threshold;
            if (nvm_fail) begin
               phase_next = TWIS_FAILHIZ;
            end else if (!nvm_customer_prog) begin
               phase_next = TWIS_SEARCH;
            end else begin
               phase_next = TWIS_INITIAL;
            end
         end
         TWIS_SEARCH: begin
            // Output held in its current state meanwhile
            cnt_next = cnt_reg + 20'h0_0001;
            if (cnt_reg >= CNT_W'(SEARCH_CYCLES - 1) && !search_busy) begin
               thr_next   = search_result;
               phase_next = TWIS_INITIAL;
               cnt_next   = CNT_RESET;
            end
         end
         TWIS_INITIAL, TWIS_PRECAL, TWIS_CAL: begin
            oe_next = want_low;
            if (phase_reg == TWIS_INITIAL && precal_done) begin
               phase_next = TWIS_PRECAL;
            end else if (phase_reg == TWIS_PRECAL && cal_done) begin
               phase_next = TWIS_CAL;
            end
         end
         TWIS_FAILHIZ: begin
            oe_next  = 1'b0;
            cnt_next = cnt_reg + 20'h0_0001;
            if (cnt_reg >= CNT_W'(FAIL_HIZ_CYCLES - TOTAL_RST_CYCLES - 2)) begin
               phase_next = TWIS_FAILLOW;
            end
         end
         default: begin
            oe_next = 1'b1;
         end
      endcase
      level_next = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase_reg <= TWIS_RESET;
         cnt_reg   <= CNT_RESET;
         cust_reg  <= 1'b0;
         pol_reg   <= 1'b0;
         thr_reg   <= THR_RESET;
         level_reg <= 1'b0;
         oe_reg    <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         cnt_reg   <= cnt_next;
         cust_reg  <= cust_next;
         pol_reg   <= pol_next;
         // Late reprogramming reaches customer-programmed comparison
         thr_reg   <= (cust_reg && phase_reg != TWIS_LOAD)
                      ? stored_start_threshold : thr_next;
         level_reg <= level_next;
         oe_reg    <= oe_next;
      end
   end

   assign out_pin_o  = level_reg;
   assign out_pin_oe = oe_reg;
   assign phase      = phase_reg;

   // Pin readback through three flops; change once last two agree
   logic pin_seen_reg;
   logic pin_seen_next;
   always_comb begin
      pin_seen_next = pin_seen_reg;
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
         pin_seen_next = pin_sync_reg[2];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_sync_reg <= 3'b111;
         pin_seen_reg <= 1'b1;
      end else begin
         pin_sync_reg <= {pin_sync_reg[1:0], out_pin_in};
         pin_seen_reg <= pin_seen_next;
      end
   end

   // Events: output switched, search finished, failure lockout
   assign ev[EV_SWITCH] = (oe_next != oe_reg);
   assign ev[EV_SEARCH] = (phase_reg == TWIS_SEARCH)
                          && (phase_next == TWIS_INITIAL);
   assign ev[EV_FAIL]   = (phase_reg == TWIS_FAILHIZ)
                          && (phase_next == TWIS_FAILLOW);
   assign wr_irq_st = avs_write && ack_reg && (avs_address == ADDR_IRQST);

   // Bus slave: one wait cycle, then acknowledge
   // Writes land only at the edge that sees waitrequest low
   always_comb begin
      ack_next     = (avs_read || avs_write) && !ack_reg;
      rdata_next   = rdata_reg;
      hyst_next    = hyst_reg;
      irq_msk_next = irq_msk_reg;
      irq_st_next  = irq_st_reg;
      if (wr_irq_st) begin
         irq_st_next = irq_st_reg & ~avs_writedata[EV_W-1:0];
      end
      irq_st_next = irq_st_next | ev; // Set beats clear
      if (avs_write && ack_reg) begin
         if (avs_address == ADDR_CTRL) begin
            hyst_next = avs_writedata[FIELD_W-1:0];
         end else if (avs_address == ADDR_IRQMSK) begin
            irq_msk_next = avs_writedata[EV_W-1:0];
         end
      end
      if (avs_read && !ack_reg) begin
         if (avs_address == ADDR_CTRL) begin
            rdata_next = {20'h0_0000, hyst_reg};
         end else if (avs_address == ADDR_STATUS) begin
            rdata_next = {12'h000, thr_reg, 2'b00, pin_seen_reg,
                          search_busy, cust_reg, phase_reg};
         end else if (avs_address == ADDR_IRQST) begin
            rdata_next = {29'h0000_0000, irq_st_reg};
         end else if (avs_address == ADDR_IRQMSK) begin
            rdata_next = {29'h0000_0000, irq_msk_reg};
         end else begin
            rdata_next = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_reg     <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         hyst_reg    <= HYST_DEFAULT;
         irq_msk_reg <= 3'b000;
         irq_st_reg  <= 3'b000;
      end else begin
         ack_reg     <= ack_next;
         rdata_reg   <= rdata_next;
         hyst_reg    <= hyst_next;
         irq_msk_reg <= irq_msk_next;
         irq_st_reg  <= irq_st_next;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
   assign avs_readdata    = rdata_reg;
   assign irq             = |(irq_st_reg & irq_msk_reg);
endmodule : twis_top

// *** twis_top_sva.sv ***
// Port checker of the tooth wheel start-up switch
module twis_top_sva
   import twis_pkg::*;
#(
   parameter int unsigned FAIL_HIZ_CYCLES  = FAIL_HIZ_CYC,
   parameter int unsigned TOTAL_RST_CYCLES = TOTAL_RST_CYC,
   parameter int unsigned SEARCH_CYCLES    = SEARCH_CYC
)
(
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic               sample_vld,
   input wire logic [FIELD_W-1:0] field,
   input wire logic               nvm_customer_prog,
   input wire logic               nvm_polarity,
   input wire logic               nvm_fail,
   input wire logic [FIELD_W-1:0] stored_start_threshold,
   input wire logic               out_pin_o,
   input wire logic               out_pin_oe,
   input wire logic [2:0]         phase,
   input wire logic               avs_read,
   input wire logic               avs_write,
   input wire logic               avs_waitrequest
);
   logic [CNT_W-1:0] rst_cnt_reg;
   logic [CNT_W-1:0] rst_cnt_next;
   // Counts cycles spent in reset phase since release
   always_comb begin
      rst_cnt_next = rst_cnt_reg;
      if (phase == 3'h0) begin
         rst_cnt_next = rst_cnt_reg + 20'h0_0001;
      end
   end
   always_ff @(posedge clk) begin
      rst_cnt_reg <= rst_n ? rst_cnt_next : CNT_RESET;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   reset_state_a: assert property (disable iff (1'b0)
      !rst_n |=> phase == 3'h0 && !out_pin_oe) else $error("bad reset state");
   open_drain_a: assert property (out_pin_o == 1'b0)
      else $error("open drain drives high");
   rst_len_a: assert property (phase == 3'h0
      |-> rst_cnt_reg <= TOTAL_RST_CYCLES + 3) else $error("reset too long");
   load_pick_a: assert property (phase == 3'h1 && !nvm_fail
      |=> phase == ($past(nvm_customer_prog) ? 3'h3 : 3'h2))
      else $error("wrong phase after load");
   search_hold_a: assert property (phase == 3'h2 |-> !out_pin_oe)
      else $error("output moved in search");
   fail_float_a: assert property (phase == 3'h6 |-> !out_pin_oe)
      else $error("output not floating");
   fail_lock_a: assert property (phase == 3'h7
      |=> phase == 3'h7 && out_pin_oe) else $error("lockout left");
   tooth_out_a: assert property (phase == 3'h3 && nvm_customer_prog
      && sample_vld && {1'b0, field} > {1'b0, stored_start_threshold} + 13'h0080
      |-> ##2 out_pin_oe == !nvm_polarity) else $error("tooth level wrong");
   notch_out_a: assert property (phase == 3'h3 && nvm_customer_prog
      && sample_vld && {1'b0, field} + 13'h0080 < {1'b0, stored_start_threshold}
      |-> ##2 out_pin_oe == nvm_polarity) else $error("notch level wrong");
   bus_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus answer late");
endmodule : twis_top_sva

// *** twis_ctrl_model.sv ***
// Controller side of the open-drain output line
module twis_ctrl_model (
   input  wire logic out_pin_o,
   input  wire logic out_pin_oe,
   output      logic line_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pull-up wins whenever the device lets go of the line
   assign line_level = out_pin_oe ? out_pin_o : 1'h1;
endmodule : twis_ctrl_model

// *** twis_top_tb_top.sv ***
// Testbench of the tooth wheel start-up switch
module twis_top_tb_top
   import twis_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic pol; logic [11:0] thr; logic [11:0] f; logic exp;
   } twis_row_s;
   localparam int unsigned TR = 20;
   localparam int unsigned SR = 40;
   localparam int unsigned FH = 80;
   logic clk = 1'h0, rst_n = 1'h0, sv_m = 1'h0, cust = 1'h1, pol = 1'h0;
   logic sv_a = 1'h0, sv;
   logic fail = 1'h0, pre = 1'h0, cal = 1'h0, rd = 1'h0, wr = 1'h0;
   logic auto_smp = 1'h0;
   logic [11:0] field = 12'h0000, thr = 12'h0400;
   logic [3:0] addr = 4'h0;
   logic [31:0] wd = 32'h0000_0000, rdata, r;
   logic o, oe, pin, wreq, irq;
   logic [2:0] phase;
   int mismatches = 0, samples_checked = 0, n;
   twis_row_s rows[4] = '{'{1'h0, 12'h0400, 12'h0500, 1'h1},
      '{1'h0, 12'h0400, 12'h0300, 1'h0}, '{1'h1, 12'h0400, 12'h0500, 1'h0},
      '{1'h1, 12'h0400, 12'h0300, 1'h1}};
   // Expected oe in bit 12, sample in bits 11:0, threshold 0x400
   logic [12:0] hs[5] = '{13'h0410, 13'h1411, 13'h13F0, 13'h03EF, 13'h0408};
   always #5 clk = ~clk;
   // Manual and free-running strobes kept apart, one driver each
   always @(posedge clk) sv_a <= auto_smp ? ~sv_a : 1'h0;
   assign sv = sv_m | sv_a;
   twis_top #(.FAIL_HIZ_CYCLES(FH), .TOTAL_RST_CYCLES(TR), .SEARCH_CYCLES(SR))
   i_dut (.clk(clk), .rst_n(rst_n), .sample_vld(sv), .field(field),
      .nvm_customer_prog(cust), .nvm_polarity(pol), .nvm_fail(fail),
      .stored_start_threshold(thr), .out_pin_in(pin), .out_pin_o(o),
      .out_pin_oe(oe), .phase(phase), .precal_done(pre), .cal_done(cal),
      .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_readdata(rdata), .avs_waitrequest(wreq), .irq(irq));
   twis_ctrl_model i_ctrl (.out_pin_o(o), .out_pin_oe(oe), .line_level(pin));
   task summarize;
      $display("TB: %0d checked, %0d mismatches", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize
   task fault(string s);
      mismatches++;
      $display("ERROR %0t %s", $time, s);
   endtask : fault
   // Values are those standing just before the edge of the call
   task chk1(logic g, logic e);
      samples_checked++;
      if (g !== e) fault($sformatf("bit %b exp %b", g, e));
   endtask : chk1
   task chk32(logic [31:0] g, logic [31:0] e);
      samples_checked++;
      if (g !== e) fault($sformatf("word %h exp %h", g, e));
   endtask : chk32
   task bus(logic w, logic [3:0] a, logic [31:0] d);
      int i;
      @(posedge clk);
      rd <= !w; wr <= w; addr <= a; wd <= d;
      // Request stands until the edge that sees waitrequest low
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (wreq === 1'h0) break;
      end
      r = rdata;
      rd <= 1'h0; wr <= 1'h0;
      if (i == 50) begin fault("bus timeout"); summarize(); end
   endtask : bus
   task wait_ph(logic [2:0] p);
      for (n = 0; n < 400 && phase !== p; n++) @(posedge clk);
      if (phase !== p) begin fault("phase timeout"); summarize(); end
   endtask : wait_ph
   task do_reset;
      @(posedge clk) rst_n <= 1'h0;
      // Second edge is the first to show the reset values
      repeat (2) @(posedge clk);
      chk1(oe, 1'h0);
      chk32(32'(phase), 32'h0000_0000);
      @(posedge clk) rst_n <= 1'h1;
   endtask : do_reset
   task smp(logic [11:0] f);
      @(posedge clk) begin sv_m <= 1'h1; field <= f; end
      @(posedge clk) sv_m <= 1'h0;
      repeat (2) @(posedge clk);
   endtask : smp
   initial begin
      foreach (rows[i]) begin
         pol <= rows[i].pol; thr <= rows[i].thr;
         do_reset();
         wait_ph(3'h3);
         smp(rows[i].f);
         chk1(oe, rows[i].exp);
         chk1(pin, !rows[i].exp);
      end
      $display("TB: polarity rows done");
      pol <= 1'h0;
      do_reset();
      wait_ph(3'h3);
      foreach (hs[i]) begin smp(hs[i][11:0]); chk1(oe, hs[i][12]); end
      smp(12'h0500);
      thr <= 12'h0600;
      smp(12'h0500);
      chk1(oe, 1'h0);
      $display("TB: hysteresis done");
      bus(1'h0, ADDR_CTRL, 0); chk32(r, 32'h0000_0010);
      bus(1'h1, ADDR_CTRL, 32'h0000_0020);
      bus(1'h0, ADDR_CTRL, 0); chk32(r, 32'h0000_0020);
      bus(1'h0, 4'h2, 0); chk32(r, 32'h0000_0000);
      bus(1'h0, ADDR_STATUS, 0); chk32(r & 32'h000F_FF3F, 32'h0006_002B);
      bus(1'h0, ADDR_IRQST, 0); chk32(r & 32'h1, 32'h1);
      bus(1'h1, ADDR_IRQMSK, 32'h0000_0001); @(posedge clk); chk1(irq, 1'h1);
      bus(1'h1, ADDR_IRQST, 32'h0000_0001); @(posedge clk); chk1(irq, 1'h0);
      bus(1'h1, ADDR_IRQMSK, 32'h0000_0000);
      smp(12'h0700); chk1(irq, 1'h0);
      $display("TB: registers done");
      pre <= 1'h1; wait_ph(3'h4); chk32(32'(phase), 32'h0000_0004);
      cal <= 1'h1; wait_ph(3'h5); chk32(32'(phase), 32'h0000_0005);
      pre <= 1'h0; cal <= 1'h0;
      do_reset(); wait_ph(3'h3); chk1(oe, 1'h0);
      $display("TB: phases done");
      cust <= 1'h0; field <= 12'h02A5; auto_smp <= 1'h1;
      do_reset(); wait_ph(3'h2); wait_ph(3'h3);
      chk1(n >= SR - 2, 1'h1);
      bus(1'h0, ADDR_STATUS, 0); chk32(r & 32'h000F_FF00, 32'h0002_A500);
      bus(1'h0, ADDR_IRQST, 0); chk32(r & 32'h2, 32'h2);
      @(posedge clk) auto_smp <= 1'h0;
      @(posedge clk) sv_m <= 1'h0;
      $display("TB: search done");
      fail <= 1'h1;
      do_reset();
      repeat (FH - 20) @(posedge clk);
      chk1(oe, 1'h0);
      wait_ph(3'h7); repeat (20) @(posedge clk);
      chk1(oe, 1'h1);
      bus(1'h0, ADDR_IRQST, 0); chk32(r & 32'h4, 32'h4);
      $display("TB: failure done");
      summarize();
   end
endmodule : twis_top_tb_top
bind twis_top twis_top_sva #(.FAIL_HIZ_CYCLES(FAIL_HIZ_CYCLES),
   .TOTAL_RST_CYCLES(TOTAL_RST_CYCLES), .SEARCH_CYCLES(SEARCH_CYCLES))
   i_sva (.clk, .rst_n, .sample_vld, .field, .nvm_customer_prog,
   .nvm_polarity, .nvm_fail, .stored_start_threshold, .out_pin_o,
   .out_pin_oe, .phase, .avs_read, .avs_write, .avs_waitrequest);
